// file: rtl/tdc_pkg.sv
// Constants for the trim and dither configuration register bank.
// Assumes a 32-bit classic Wishbone bus with one byte of data per word.
package tdc_pkg;

	// ----------------------------------------------------------------
	// Bus shape
	// ----------------------------------------------------------------
	localparam int TDC_ADR_W = 12;
	localparam int TDC_DAT_W = 32;
	localparam int TDC_SEL_W = 4;
	localparam int TDC_REG_W = 8;
	localparam int TDC_IDX_W = 10;
	localparam int TDC_ADR_LSB = 2;
	localparam int TDC_LANE = 0;
	localparam logic [TDC_DAT_W-1:0] TDC_RD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Register entries, word index, byte address is four times it
	// ----------------------------------------------------------------
	localparam int TDC_NREG = 7;
	localparam int TDC_E_GAIN_A = 0;
	localparam int TDC_E_GAIN_B = 1;
	localparam int TDC_E_VREF = 2;
	localparam int TDC_E_TERM_A = 3;
	localparam int TDC_E_TERM_B = 4;
	localparam int TDC_E_DITH = 5;
	localparam int TDC_E_SKEW = 6;

	localparam logic [TDC_IDX_W-1:0] TDC_IDX [TDC_NREG] = '{
		10'h07a, 10'h07b, 10'h07c, 10'h07e, 10'h07f, 10'h09d, 10'h102
	};

	// Entries whose value comes from the fuse word after reset
	localparam logic [TDC_NREG-1:0] TDC_HAS_FUSE = 7'h5f;

	// ----------------------------------------------------------------
	// Reset values and fields
	// ----------------------------------------------------------------
	localparam logic [TDC_REG_W-1:0] TDC_ZERO_RST = 8'h00;
	localparam logic [TDC_REG_W-1:0] TDC_DITH_RST = 8'h01;
	localparam logic [3:0] TDC_VREF_RSVD_RST = 4'h0;
	localparam int TDC_VREF_ADJ_W = 4;
	localparam int TDC_DITH_EN_BIT = 0;
	localparam int TDC_DITH_AMP_BIT = 1;
	localparam int TDC_DITH_ERR_BIT = 2;

endpackage

// file: rtl/tdc_sync3.sv
// Three-stage level synchroniser with agreement filter.
// Assumes the input is a slow level from outside the core_clk domain.
`timescale 1ns/1ns
module tdc_sync3 (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic async_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// First stage feeds only the second one
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else if (clk_en) begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts once the late stages agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			level_o <= 1'b0;
		end else if (clk_en && (s2_q == s3_q)) begin
			level_o <= s3_q;
		end
	end
endmodule

// file: rtl/tdc_fuse_load.sv
// One-shot fuse load strobe after reset release.
// Assumes fuse values are stable from reset release onward.
`timescale 1ns/1ns
module tdc_fuse_load (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	output logic load_o,
	output logic done_o
);
	// Fuses are caught by a clocked load, never by the reset itself
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_o <= 1'b0;
			load_o <= 1'b0;
		end else if (clk_en) begin
			done_o <= 1'b1;
			load_o <= !done_o;
		end
	end
endmodule

// file: rtl/tdc_regs.sv
// Trim and dither configuration register bank, Wishbone slave.
// Assumes fuse values from same-clock logic and an external mode pin.
`timescale 1ns/1ns
module tdc_regs (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [tdc_pkg::TDC_ADR_W-1:0] wb_adr_i,
	input wire logic [tdc_pkg::TDC_DAT_W-1:0] wb_dat_i,
	input wire logic [tdc_pkg::TDC_SEL_W-1:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [tdc_pkg::TDC_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [tdc_pkg::TDC_REG_W-1:0] fuse_gain_a,
	input wire logic [tdc_pkg::TDC_REG_W-1:0] fuse_gain_b,
	input wire logic [tdc_pkg::TDC_VREF_ADJ_W-1:0] fuse_vref,
	input wire logic [tdc_pkg::TDC_REG_W-1:0] fuse_term_a,
	input wire logic [tdc_pkg::TDC_REG_W-1:0] fuse_term_b,
	input wire logic [tdc_pkg::TDC_REG_W-1:0] fuse_skew,
	input wire logic dual_channel_mode,
	output logic [tdc_pkg::TDC_REG_W-1:0] channel_a_gain_adjust,
	output logic [tdc_pkg::TDC_REG_W-1:0] channel_b_gain_adjust,
	output logic [tdc_pkg::TDC_REG_W-1:0] reference_voltage_adjust,
	output logic [tdc_pkg::TDC_REG_W-1:0] input_a_termination_adjust,
	output logic [tdc_pkg::TDC_REG_W-1:0] input_b_termination_adjust,
	output logic dither_enable,
	output logic dither_amplitude_select,
	output logic rounding_error_target,
	output logic [tdc_pkg::TDC_REG_W-1:0] bank0_phase0_skew_adjust,
	output logic skew_active
);
	import tdc_pkg::*;

	// ----------------------------------------------------------------
	// Internal signals
	// ----------------------------------------------------------------
	logic [TDC_REG_W-1:0] regs_q [TDC_NREG];
	logic [TDC_REG_W-1:0] fuse_word [TDC_NREG];
	logic [TDC_NREG-1:0] hit;
	logic [TDC_NREG-1:0] wr_en;
	logic [TDC_IDX_W-1:0] idx;
	logic [TDC_REG_W-1:0] wr_byte;
	logic [TDC_REG_W-1:0] rd_byte;
	logic req;
	logic any_hit;
	logic load;
	logic load_done;
	logic dual_level;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	tdc_sync3 u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.async_i(dual_channel_mode),
		.level_o(dual_level)
	);

	tdc_fuse_load u_fuse (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load_o(load),
		.done_o(load_done)
	);

	// ----------------------------------------------------------------
	// Fuse and reset words per entry
	// ----------------------------------------------------------------
	assign fuse_word[TDC_E_GAIN_A] = fuse_gain_a;
	assign fuse_word[TDC_E_GAIN_B] = fuse_gain_b;
	assign fuse_word[TDC_E_VREF] = {TDC_VREF_RSVD_RST, fuse_vref};
	assign fuse_word[TDC_E_TERM_A] = fuse_term_a;
	assign fuse_word[TDC_E_TERM_B] = fuse_term_b;
	assign fuse_word[TDC_E_DITH] = TDC_DITH_RST;
	assign fuse_word[TDC_E_SKEW] = fuse_skew;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign idx = wb_adr_i[TDC_ADR_W-1:TDC_ADR_LSB];
	assign wr_byte = wb_dat_i[TDC_LANE*TDC_REG_W +: TDC_REG_W];
	// One request per cycle window; ack high blocks a second take
	assign req = clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_comb begin
		rd_byte = TDC_ZERO_RST;
		any_hit = 1'b0;
		for (int i = 0; i < TDC_NREG; i++) begin
			if (hit[i]) begin
				rd_byte = regs_q[i];
				any_hit = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Reset gives a known value; fuse data only lands on the load
	// strobe, since a port value may not enter an async reset.
	generate
		for (genvar g = 0; g < TDC_NREG; g++) begin : g_reg
			// Constant, so the async branch never samples a net
			localparam logic [TDC_REG_W-1:0] RST_VAL =
				(g == TDC_E_DITH) ? TDC_DITH_RST : TDC_ZERO_RST;
			assign hit[g] = (idx == TDC_IDX[g]);
			assign wr_en[g] = req && wb_we_i && wb_sel_i[TDC_LANE] &&
				hit[g];
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					regs_q[g] <= RST_VAL;
				end else if (clk_en) begin
					if (load && TDC_HAS_FUSE[g]) begin
						regs_q[g] <= fuse_word[g];
					end else if (wr_en[g]) begin
						regs_q[g] <= wr_byte;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Every access, mapped or not, is acked one cycle after the take
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else if (clk_en) begin
			wb_ack_o <= req;
		end
	end

	// Unmapped reads and the upper lanes return zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= TDC_RD_ZERO;
		end else if (clk_en && req) begin
			if (!wb_we_i && any_hit) begin
				wb_dat_o <= {{(TDC_DAT_W-TDC_REG_W){1'b0}}, rd_byte};
			end else begin
				wb_dat_o <= TDC_RD_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------
	// Trims drive the analog side straight from storage, no commit step
	assign channel_a_gain_adjust = regs_q[TDC_E_GAIN_A];
	assign channel_b_gain_adjust = regs_q[TDC_E_GAIN_B];
	assign reference_voltage_adjust = regs_q[TDC_E_VREF];
	assign input_a_termination_adjust = regs_q[TDC_E_TERM_A];
	assign input_b_termination_adjust = regs_q[TDC_E_TERM_B];
	assign dither_enable = regs_q[TDC_E_DITH][TDC_DITH_EN_BIT];
	assign dither_amplitude_select =
		regs_q[TDC_E_DITH][TDC_DITH_AMP_BIT];
	assign rounding_error_target =
		regs_q[TDC_E_DITH][TDC_DITH_ERR_BIT];

	// Skew only reaches bank 0 in dual-channel mode; a neutral zero
	// otherwise, one cycle behind the stored value.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bank0_phase0_skew_adjust <= TDC_ZERO_RST;
			skew_active <= 1'b0;
		end else if (clk_en) begin
			skew_active <= dual_level;
			if (dual_level) begin
				bank0_phase0_skew_adjust <= regs_q[TDC_E_SKEW];
			end else begin
				bank0_phase0_skew_adjust <= TDC_ZERO_RST;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_gain_a_write;
		@(posedge core_clk) disable iff (rst)
		(wr_en[TDC_E_GAIN_A] && !load) |=>
			channel_a_gain_adjust == $past(wr_byte);
	endproperty
	a_gain_a_write: assert property (p_gain_a_write)
		else $error("gain A write not applied");

	property p_gain_b_write;
		@(posedge core_clk) disable iff (rst)
		(wr_en[TDC_E_GAIN_B] && !load) |=>
			channel_b_gain_adjust == $past(wr_byte);
	endproperty
	a_gain_b_write: assert property (p_gain_b_write)
		else $error("gain B write not applied");

	property p_vref_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			reference_voltage_adjust ==
			{TDC_VREF_RSVD_RST, $past(fuse_vref)};
	endproperty
	a_vref_fuse: assert property (p_vref_fuse)
		else $error("reference trim fuse load wrong");

	property p_term_a_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			input_a_termination_adjust == $past(fuse_term_a);
	endproperty
	a_term_a_fuse: assert property (p_term_a_fuse)
		else $error("termination A fuse load wrong");

	property p_term_b_write;
		@(posedge core_clk) disable iff (rst)
		(wr_en[TDC_E_TERM_B] && !load) |=>
			input_b_termination_adjust == $past(wr_byte);
	endproperty
	a_term_b_write: assert property (p_term_b_write)
		else $error("termination B write not applied");

	property p_dith_reset;
		@(posedge core_clk) disable iff (rst)
		load |-> (regs_q[TDC_E_DITH] == TDC_DITH_RST && dither_enable);
	endproperty
	a_dith_reset: assert property (p_dith_reset)
		else $error("dither control not at reset value");

	property p_dith_amp;
		@(posedge core_clk) disable iff (rst)
		wr_en[TDC_E_DITH] |=>
			dither_amplitude_select ==
			$past(wr_byte[TDC_DITH_AMP_BIT]) &&
			rounding_error_target == $past(wr_byte[TDC_DITH_ERR_BIT]);
	endproperty
	a_dith_amp: assert property (p_dith_amp)
		else $error("dither field write not applied");

	property p_skew_gate;
		@(posedge core_clk) disable iff (rst)
		(clk_en && !dual_level) |=>
			bank0_phase0_skew_adjust == TDC_ZERO_RST && !skew_active;
	endproperty
	a_skew_gate: assert property (p_skew_gate)
		else $error("skew applied outside dual-channel mode");

	property p_skew_pass;
		@(posedge core_clk) disable iff (rst)
		(clk_en && dual_level) |=>
			bank0_phase0_skew_adjust == $past(regs_q[TDC_E_SKEW]);
	endproperty
	a_skew_pass: assert property (p_skew_pass)
		else $error("skew not applied in dual-channel mode");

	property p_read_live;
		@(posedge core_clk) disable iff (rst)
		(req && !wb_we_i && hit[TDC_E_GAIN_A]) |=>
			wb_ack_o && wb_dat_o == {{(TDC_DAT_W-TDC_REG_W){1'b0}},
			$past(regs_q[TDC_E_GAIN_A])};
	endproperty
	a_read_live: assert property (p_read_live)
		else $error("read did not return live value");

	property p_ack_once;
		@(posedge core_clk) disable iff (rst)
		(wb_ack_o && clk_en) |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held for more than one cycle");

	property p_gain_a_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			channel_a_gain_adjust == $past(fuse_gain_a);
	endproperty
	a_gain_a_fuse: assert property (p_gain_a_fuse)
		else $error("gain A fuse load wrong");

	property p_gain_b_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			channel_b_gain_adjust == $past(fuse_gain_b);
	endproperty
	a_gain_b_fuse: assert property (p_gain_b_fuse)
		else $error("gain B fuse load wrong");

	property p_vref_write;
		@(posedge core_clk) disable iff (rst)
		(wr_en[TDC_E_VREF] && !load) |=>
			reference_voltage_adjust == $past(wr_byte);
	endproperty
	a_vref_write: assert property (p_vref_write)
		else $error("reference trim write not applied");

	property p_term_a_write;
		@(posedge core_clk) disable iff (rst)
		(wr_en[TDC_E_TERM_A] && !load) |=>
			input_a_termination_adjust == $past(wr_byte);
	endproperty
	a_term_a_write: assert property (p_term_a_write)
		else $error("termination A write not applied");

	property p_term_b_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			input_b_termination_adjust == $past(fuse_term_b);
	endproperty
	a_term_b_fuse: assert property (p_term_b_fuse)
		else $error("termination B fuse load wrong");

	property p_dith_hold;
		@(posedge core_clk) disable iff (rst)
		(load && !wr_en[TDC_E_DITH]) |=>
			$stable(regs_q[TDC_E_DITH]);
	endproperty
	a_dith_hold: assert property (p_dith_hold)
		else $error("fuse load disturbed dither control");

	property p_skew_fuse;
		@(posedge core_clk) disable iff (rst)
		(load && clk_en) |=>
			regs_q[TDC_E_SKEW] == $past(fuse_skew);
	endproperty
	a_skew_fuse: assert property (p_skew_fuse)
		else $error("skew fuse load wrong");

	property p_freeze;
		@(posedge core_clk) disable iff (rst)
		!clk_en |=> $stable(wb_ack_o) && $stable(wb_dat_o) &&
			$stable(skew_active) && $stable(bank0_phase0_skew_adjust) &&
			$stable(channel_a_gain_adjust);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	c_write_gain: cover property (@(posedge core_clk) disable iff (rst)
		wr_en[TDC_E_GAIN_A] ##2 wb_ack_o == 1'b0);
	c_read_dith: cover property (@(posedge core_clk) disable iff (rst)
		req && !wb_we_i && hit[TDC_E_DITH]);
	c_skew_on: cover property (@(posedge core_clk) disable iff (rst)
		$rose(skew_active));
	c_unmapped: cover property (@(posedge core_clk) disable iff (rst)
		req && !any_hit && load_done);
endmodule

// file: tb/tdc_tb.sv
// Self-checking bench for the trim and dither register bank.
// Assumes ack one edge after take and fuse load two edges after reset.
`timescale 1ns/1ns
module testbench;
	import tdc_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	logic clk_en = 1;
	logic [11:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [3:0] sel = '0;
	logic we = 0;
	logic cyc = 0;
	logic stb = 0;
	logic dual = 0;
	logic [31:0] rdat;
	logic ack;
	logic [7:0] f [6] = '{default: 8'h00};
	logic [7:0] o [5];
	logic [7:0] oskew;
	logic en;
	logic amp;
	logic err;
	logic act;
	logic [7:0] pat [7] = '{8'h11, 8'hee, 8'hf3, 8'h80, 8'h7f, 8'hfd, 8'h42};
	int mismatches = 0;
	int checked = 0;

	always #5 core_clk = ~core_clk;

	tdc_regs dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fuse_gain_a(f[0]), .fuse_gain_b(f[1]), .fuse_vref(f[2][3:0]),
		.fuse_term_a(f[3]), .fuse_term_b(f[4]), .fuse_skew(f[5]),
		.dual_channel_mode(dual), .channel_a_gain_adjust(o[0]),
		.channel_b_gain_adjust(o[1]), .reference_voltage_adjust(o[2]),
		.input_a_termination_adjust(o[3]),
		.input_b_termination_adjust(o[4]), .dither_enable(en),
		.dither_amplitude_select(amp), .rounding_error_target(err),
		.bank0_phase0_skew_adjust(oskew), .skew_active(act));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	task automatic bus(logic w, logic [11:0] a, logic [31:0] d,
		logic [3:0] s, output logic [31:0] q);
		int n;
		@(posedge core_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (ack !== 1'b1) begin
			$display("[FAIL] ack wait expected 1 seen %b", ack);
			mismatches++;
			close_out();
		end
	endtask

	task automatic wr(int i, logic [7:0] v);
		logic [31:0] q;
		bus(1, {TDC_IDX[i], 2'b00}, {24'h0, v}, 4'hf, q);
	endtask

	task automatic rd(int i, output logic [31:0] q);
		bus(0, {TDC_IDX[i], 2'b00}, 32'h0, 4'hf, q);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Fuse values change only while reset is held
	task automatic do_reset(logic [7:0] b);
		@(posedge core_clk);
		rst <= 1;
		for (int k = 0; k < 6; k++) begin
			f[k] <= b + 8'(k * 53);
		end
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		for (int k = 0; k < 5; k++) begin
			chk("trim in reset", 0, o[k]);
		end
		chk("skew in reset", 0, oskew);
		chk("dither enable", 1, en);
		chk("dither amplitude", 0, amp);
		chk("error target", 0, err);
		repeat (18) @(posedge core_clk);
		rst <= 0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic t_fuse;
		logic [31:0] q;
		logic [7:0] e [7];
		e = '{f[0], f[1], {4'h0, f[2][3:0]}, f[3], f[4], 8'h01, f[5]};
		for (int i = 0; i < 7; i++) begin
			rd(i, q);
			chk($sformatf("fuse %0d", i),
				{24'h0, e[i]}, q);
		end
	endtask

	task automatic t_write_back;
		logic [31:0] q;
		logic [7:0] p;
		for (int i = 0; i < 7; i++) begin
			wr(i, pat[i]);
			@(negedge core_clk);
			p = (i == 5) ? {5'h0, err, amp, en} : (i == 6) ? oskew : o[i];
			chk($sformatf("port %0d", i), (i == 5) ? pat[i] & 8'h07 :
				(i == 6) ? 8'h00 : pat[i], p);
		end
		for (int i = 0; i < 7; i++) begin
			rd(i, q);
			chk($sformatf("read %0d", i),
				{24'h0, pat[i]}, q);
		end
	endtask

	task automatic t_dither;
		for (int v = 0; v < 8; v++) begin
			wr(5, 8'(v));
			@(negedge core_clk);
			chk("dither bits", 32'(v), {5'h0, err, amp, en});
		end
	endtask

	// Unmapped, unselected byte lane, and stray upper data bits
	task automatic t_refused;
		logic [31:0] q;
		bus(1, 12'h000, 32'h5a, 4'hf, q);
		bus(0, 12'h000, 32'h0, 4'hf, q);
		chk("unmapped read", 0, q);
		bus(1, 12'h1e8, 32'h99, 4'he, q);
		rd(0, q);
		chk("lane off write", {24'h0, pat[0]}, q);
		bus(1, 12'h1ee, 32'hffff_ff33, 4'hf, q);
		rd(1, q);
		chk("upper data bits", 32'h33, q);
	endtask

	task automatic wait_act(logic v);
		int n;
		n = 0;
		while (act !== v && n < 10) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		@(negedge core_clk);
		chk("mode seen", v, act);
		if (act !== v) begin
			close_out();
		end
	endtask

	task automatic t_skew;
		wr(6, 8'h5c);
		wait_act(0);
		chk("skew single", 0, oskew);
		@(posedge core_clk);
		dual <= 1;
		wait_act(1);
		chk("skew dual", 8'h5c, oskew);
		wr(6, 8'ha3);
		@(posedge core_clk);
		@(negedge core_clk);
		chk("skew live", 8'ha3, oskew);
		@(posedge core_clk);
		dual <= 0;
		wait_act(0);
		chk("skew off again", 0, oskew);
	endtask

	// Clock enable low must hide a mode change until it returns
	task automatic t_freeze;
		@(posedge core_clk);
		clk_en <= 0;
		dual <= 1;
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		chk("frozen mode", 0, act);
		chk("frozen skew", 0, oskew);
		@(posedge core_clk);
		clk_en <= 1;
		wait_act(1);
		chk("skew after thaw", 8'ha3, oskew);
	endtask

	initial begin
		do_reset(8'h5a);
		t_fuse();
		t_write_back();
		t_dither();
		t_refused();
		t_skew();
		t_freeze();
		do_reset(8'hc7);
		t_fuse();
		close_out();
	end
endmodule
